// *** rtcam_pkg.sv ***
// Purpose: shared constants of the real-time clock core
// Assumes: 20 MHz system clock, AHB-Lite register access
// Notes:   register index times four gives the byte address
package rtcam_pkg;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned MISS_TIME_NS      = 100000;
  localparam int unsigned MISS_CYCLES       = MISS_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_TIME_NS     = 2000000;
  localparam int unsigned BLANK_CYCLES      = BLANK_TIME_NS / CLK_PERIOD_NS;

  // ***********************************************************
  // register indices (byte address = index * 4)
  // ***********************************************************
  localparam logic [7:0]  IDX_CAPTURE0      = 8'h00;
  localparam logic [7:0]  IDX_CAPTURE1      = 8'h01;
  localparam logic [7:0]  IDX_CAPTURE2      = 8'h02;
  localparam logic [7:0]  IDX_CAPTURE3      = 8'h03;
  localparam logic [7:0]  IDX_MAIN_CTRL     = 8'h04;
  localparam logic [7:0]  IDX_OSC_CTRL      = 8'h05;
  localparam logic [7:0]  IDX_OSC_CFG       = 8'h06;
  localparam logic [7:0]  IDX_PIN_CFG       = 8'h07;
  localparam logic [7:0]  IDX_ALARM_MATCH_BYTE0        = 8'h08;
  localparam logic [7:0]  IDX_ALARM_MATCH_BYTE1        = 8'h09;
  localparam logic [7:0]  IDX_ALARM_MATCH_BYTE2        = 8'h0a;
  localparam logic [7:0]  IDX_ALARM_MATCH_BYTE3        = 8'h0b;

  // ***********************************************************
  // main control fields
  // ***********************************************************
  localparam int unsigned MC_OSC_ENABLE     = 7;
  localparam int unsigned MC_MCLK_ENABLE    = 6;
  localparam int unsigned MC_OSC_FAIL       = 5;
  localparam int unsigned MC_TIMER_RUN      = 4;
  localparam int unsigned MC_ALARM_ENABLE   = 3;
  localparam int unsigned MC_ALARM_AUTORST  = 2;
  localparam int unsigned MC_LOAD           = 1;
  localparam int unsigned MC_CAPTURE        = 0;

  // ***********************************************************
  // oscillator control fields
  // ***********************************************************
  localparam int unsigned OC_XTAL_VALID     = 4;
  localparam int unsigned OC_LFO_ENABLE     = 3;

  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [7:0]  RST_MAIN_CTRL     = 8'h00;
  localparam logic [7:0]  RST_OSC_CTRL      = 8'h00;
  localparam logic [7:0]  RST_OSC_CFG       = 8'h00;
  localparam logic [7:0]  RST_PIN_CFG       = 8'h00;
  localparam logic [31:0] RST_WORD          = 32'h0000_0000;

  // ***********************************************************
  // bus encodings
  // ***********************************************************
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'b10;
  localparam logic [2:0]  HSIZE_WORD        = 3'b010;
  localparam logic        HRESP_OKAY        = 1'b0;

endpackage : rtcam_pkg

// *** rtcam_core.sv ***
// Purpose: real-time clock counter, alarm, capture/load and clock monitor
// Assumes: oscillator and amplitude detector arrive as async pins
// Notes:   AHB-Lite slave, zero wait states, always OKAY
`timescale 1ns/1ns

// Overview of operation
// - missing-clock monitor is armed only while main control bit 6 is set
// - armed monitor sets fail flag bit 5 if oscillator stalls over 100 us
// - fail flag drives an output usable for interrupt, wake-up or reset
// - crystal valid flag reads at oscillator control bit 4, read-only
// - crystal valid flag meaningless for 2 ms after oscillator power-up
// - 32-bit counter advances each oscillator cycle while timer run is set
// - alarm event drives an output usable for interrupt, wake-up or reset
// - auto-reset clears counter one oscillator cycle after alarm deasserts
// - load and capture work while the counter runs
// - load strobe copies holding bytes into counter, then self-clears
// - capture strobe snapshots counter into holding bytes, then self-clears
// - alarm event raised when counter equals the four alarm bytes
// - clearing alarm event enable also clears the alarm flag
// - alarm flag lasts at most one oscillator cycle
// - re-enabling with unchanged alarm gives next match 2^32 cycles later
// - without auto-reset the counter wraps to zero and keeps counting
// - low-frequency source increments counter at bit 1
module rtcam_core #(
  parameter int unsigned BLANK_CYCLES = rtcam_pkg::BLANK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // oscillator pins
  input  wire logic        osc_clk_in,
  input  wire logic        xtal_amp_ok_in,
  // oscillator settings
  output logic             osc_power_out,
  output logic [7:0]       osc_control_out,
  output logic [7:0]       osc_config_out,
  output logic [7:0]       pin_config_out,
  // event outputs
  output logic             alarm_event_out,
  output logic             osc_fail_out
);

  // ***********************************************************
  // elaboration checks
  // ***********************************************************
  if (BLANK_CYCLES < 1 || BLANK_CYCLES > 32'h00ff_ffff)
  begin : g_bad_blank
    $error("BLANK_CYCLES out of range");
  end

  localparam logic [11:0] MISS_LIMIT = 12'(rtcam_pkg::MISS_CYCLES);

  // ***********************************************************
  // synchronisers
  // ***********************************************************
  logic       osc_meta_reg;
  logic       osc_sync_reg;
  logic       osc_prev_reg;
  logic       amp_meta_reg;
  logic       amp_sync_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      osc_prev_reg <= 1'b0;
      amp_meta_reg <= 1'b0;
      amp_sync_reg <= 1'b0;
    end
    else
    begin
      osc_meta_reg <= osc_clk_in;
      osc_sync_reg <= osc_meta_reg;
      osc_prev_reg <= osc_sync_reg;
      amp_meta_reg <= xtal_amp_ok_in;
      amp_sync_reg <= amp_meta_reg;
    end
  end

  logic osc_tick;
  logic osc_toggle;
  assign osc_tick   = osc_sync_reg & ~osc_prev_reg;
  assign osc_toggle = osc_sync_reg ^ osc_prev_reg;

  // ***********************************************************
  // bus address phase
  // ***********************************************************
  logic       dph_write_reg;
  logic [7:0] dph_index_reg;
  logic       dph_valid_reg;
  logic       aph_take;
  logic [7:0] aph_index;

  assign aph_take  = hsel & hready & (htrans == rtcam_pkg::HTRANS_NONSEQ);
  assign aph_index = (haddr[1:0] == 2'b00 && haddr[31:6] == 26'h0) ? {4'h0, haddr[5:2]}
                                                                    : 8'hff;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dph_write_reg <= 1'b0;
      dph_index_reg <= 8'hff;
      dph_valid_reg <= 1'b0;
    end
    else
    begin
      dph_write_reg <= aph_take & hwrite & (hsize == rtcam_pkg::HSIZE_WORD);
      dph_index_reg <= aph_index;
      dph_valid_reg <= aph_take;
    end
  end

  logic       wr_en;
  logic [7:0] wr_byte;
  assign wr_en   = dph_valid_reg & dph_write_reg;
  assign wr_byte = hwdata[7:0];

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_en && (dph_index_reg == idx);
  endfunction : wr_hit

  // ***********************************************************
  // control and configuration registers
  // ***********************************************************
  logic        osc_en_reg;
  logic        mclk_en_reg;
  logic        timer_run_reg;
  logic        alarm_en_reg;
  logic        autoreset_reg;
  logic [7:0]  osc_ctrl_reg;
  logic [7:0]  osc_cfg_reg;
  logic [7:0]  pin_cfg_reg;
  logic [31:0] alarm_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_en_reg    <= rtcam_pkg::RST_MAIN_CTRL[rtcam_pkg::MC_OSC_ENABLE];
      mclk_en_reg   <= rtcam_pkg::RST_MAIN_CTRL[rtcam_pkg::MC_MCLK_ENABLE];
      timer_run_reg <= rtcam_pkg::RST_MAIN_CTRL[rtcam_pkg::MC_TIMER_RUN];
      alarm_en_reg  <= rtcam_pkg::RST_MAIN_CTRL[rtcam_pkg::MC_ALARM_ENABLE];
      autoreset_reg <= rtcam_pkg::RST_MAIN_CTRL[rtcam_pkg::MC_ALARM_AUTORST];
      osc_ctrl_reg  <= rtcam_pkg::RST_OSC_CTRL;
      osc_cfg_reg   <= rtcam_pkg::RST_OSC_CFG;
      pin_cfg_reg   <= rtcam_pkg::RST_PIN_CFG;
    end
    else
    begin
      if (wr_hit(rtcam_pkg::IDX_MAIN_CTRL))
      begin
        osc_en_reg    <= wr_byte[rtcam_pkg::MC_OSC_ENABLE];
        mclk_en_reg   <= wr_byte[rtcam_pkg::MC_MCLK_ENABLE];
        timer_run_reg <= wr_byte[rtcam_pkg::MC_TIMER_RUN];
        alarm_en_reg  <= wr_byte[rtcam_pkg::MC_ALARM_ENABLE];
        autoreset_reg <= wr_byte[rtcam_pkg::MC_ALARM_AUTORST];
      end
      if (wr_hit(rtcam_pkg::IDX_OSC_CTRL))
      begin
        osc_ctrl_reg  <= wr_byte;
      end
      if (wr_hit(rtcam_pkg::IDX_OSC_CFG))
      begin
        osc_cfg_reg   <= wr_byte;
      end
      if (wr_hit(rtcam_pkg::IDX_PIN_CFG))
      begin
        pin_cfg_reg   <= wr_byte;
      end
    end
  end

  // ***********************************************************
  // alarm bytes
  // ***********************************************************
  // little-endian alarm bytes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_alarm
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          alarm_reg[gi*8 +: 8] <= rtcam_pkg::RST_WORD[gi*8 +: 8];
        end
        else if (wr_hit(rtcam_pkg::IDX_ALARM_MATCH_BYTE0 + 8'(gi)))
        begin
          alarm_reg[gi*8 +: 8] <= wr_byte;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // load and capture strobes
  // ***********************************************************
  logic load_req_reg;
  logic cap_req_reg;
  logic main_wr;
  assign main_wr = wr_hit(rtcam_pkg::IDX_MAIN_CTRL);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      load_req_reg <= 1'b0;
      cap_req_reg  <= 1'b0;
    end
    else
    begin
      if (main_wr && wr_byte[rtcam_pkg::MC_LOAD])
      begin
        load_req_reg <= 1'b1;
      end
      else if (load_req_reg)
      begin
        load_req_reg <= 1'b0;
      end
      if (main_wr && wr_byte[rtcam_pkg::MC_CAPTURE])
      begin
        cap_req_reg <= 1'b1;
      end
      else if (cap_req_reg)
      begin
        cap_req_reg <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // counter and capture holding bytes
  // ***********************************************************
  logic [31:0] count_reg;
  logic [31:0] capture_reg;
  logic        alarm_flag_reg;
  logic        clear_pend_reg;
  logic [31:0] count_step;
  logic [31:0] count_inc;
  logic        run_tick;

  assign count_step = osc_ctrl_reg[rtcam_pkg::OC_LFO_ENABLE] ? 32'h0000_0002
                                                              : 32'h0000_0001;
  assign count_inc  = count_reg + count_step;
  // advance on oscillator cycles while running
  assign run_tick   = osc_tick & timer_run_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= rtcam_pkg::RST_WORD;
    end
    else if (load_req_reg)
    begin
      count_reg <= capture_reg;
    end
    else if (osc_tick && clear_pend_reg)
    begin
      count_reg <= rtcam_pkg::RST_WORD;
    end
    else if (run_tick)
    begin
      count_reg <= count_inc;
    end
  end

  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_capture
      always_ff @(posedge clk_sys or posedge rst)
      begin
        if (rst)
        begin
          capture_reg[gi*8 +: 8] <= rtcam_pkg::RST_WORD[gi*8 +: 8];
        end
        else if (cap_req_reg)
        begin
          capture_reg[gi*8 +: 8] <= count_reg[gi*8 +: 8];
        end
        else if (wr_hit(rtcam_pkg::IDX_CAPTURE0 + 8'(gi)))
        begin
          capture_reg[gi*8 +: 8] <= wr_byte;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // alarm comparator
  // ***********************************************************
  logic match_now;
  // equality on the value just reached
  assign match_now = run_tick & (count_inc == alarm_reg);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      alarm_flag_reg <= 1'b0;
      clear_pend_reg <= 1'b0;
    end
    else
    begin
      if (!alarm_en_reg || (main_wr && !wr_byte[rtcam_pkg::MC_ALARM_ENABLE]))
      begin
        // disable clears the flag at the write
        alarm_flag_reg <= 1'b0;
      end
      else if (match_now)
      begin
        alarm_flag_reg <= 1'b1;
      end
      else if (osc_tick)
      begin
        // flag ends at the next oscillator tick
        alarm_flag_reg <= 1'b0;
      end
      if (osc_tick && clear_pend_reg)
      begin
        clear_pend_reg <= 1'b0;
      end
      else if (osc_tick && alarm_flag_reg && autoreset_reg && !match_now)
      begin
        clear_pend_reg <= 1'b1;
      end
    end
  end

  // ***********************************************************
  // missing-clock monitor
  // ***********************************************************
  logic [11:0] miss_cnt_reg;
  logic        osc_fail_reg;
  logic        miss_hit;
  assign miss_hit = mclk_en_reg & (miss_cnt_reg >= MISS_LIMIT);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      miss_cnt_reg <= 12'h000;
    end
    else if (!mclk_en_reg || osc_toggle)
    begin
      miss_cnt_reg <= 12'h000;
    end
    else if (!miss_hit)
    begin
      miss_cnt_reg <= miss_cnt_reg + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_fail_reg <= 1'b0;
    end
    else if (miss_hit)
    begin
      osc_fail_reg <= 1'b1;
    end
    else if (main_wr && !wr_byte[rtcam_pkg::MC_OSC_FAIL])
    begin
      osc_fail_reg <= 1'b0;
    end
  end

  // ***********************************************************
  // crystal valid blanking
  // ***********************************************************
  logic [23:0] blank_cnt_reg;
  logic        blank_done;
  logic        xtal_valid;
  assign blank_done = (blank_cnt_reg >= 24'(BLANK_CYCLES));
  assign xtal_valid = amp_sync_reg & osc_en_reg & blank_done;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      blank_cnt_reg <= 24'h000000;
    end
    else if (!osc_en_reg)
    begin
      blank_cnt_reg <= 24'h000000;
    end
    else if (!blank_done)
    begin
      blank_cnt_reg <= blank_cnt_reg + 24'h000001;
    end
  end

  // ***********************************************************
  // read mux
  // ***********************************************************
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    case (aph_index)
      rtcam_pkg::IDX_CAPTURE0: rd_byte = capture_reg[7:0];
      rtcam_pkg::IDX_CAPTURE1: rd_byte = capture_reg[15:8];
      rtcam_pkg::IDX_CAPTURE2: rd_byte = capture_reg[23:16];
      rtcam_pkg::IDX_CAPTURE3: rd_byte = capture_reg[31:24];
      rtcam_pkg::IDX_MAIN_CTRL:
        rd_byte = {osc_en_reg, mclk_en_reg, osc_fail_reg, timer_run_reg,
                   alarm_en_reg, alarm_flag_reg, load_req_reg, cap_req_reg};
      rtcam_pkg::IDX_OSC_CTRL:
      begin
        rd_byte = osc_ctrl_reg;
        rd_byte[rtcam_pkg::OC_XTAL_VALID] = xtal_valid;
      end
      rtcam_pkg::IDX_OSC_CFG:  rd_byte = osc_cfg_reg;
      rtcam_pkg::IDX_PIN_CFG:  rd_byte = pin_cfg_reg;
      rtcam_pkg::IDX_ALARM_MATCH_BYTE0:   rd_byte = alarm_reg[7:0];
      rtcam_pkg::IDX_ALARM_MATCH_BYTE1:   rd_byte = alarm_reg[15:8];
      rtcam_pkg::IDX_ALARM_MATCH_BYTE2:   rd_byte = alarm_reg[23:16];
      rtcam_pkg::IDX_ALARM_MATCH_BYTE3:   rd_byte = alarm_reg[31:24];
      default:                 rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= rtcam_pkg::HRESP_OKAY;
    end
    else
    begin
      hrdata    <= (aph_take && !hwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= rtcam_pkg::HRESP_OKAY;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      osc_power_out   <= 1'b0;
      osc_control_out <= rtcam_pkg::RST_OSC_CTRL;
      osc_config_out  <= rtcam_pkg::RST_OSC_CFG;
      pin_config_out  <= rtcam_pkg::RST_PIN_CFG;
      alarm_event_out <= 1'b0;
      osc_fail_out    <= 1'b0;
    end
    else
    begin
      osc_power_out   <= osc_en_reg;
      osc_control_out <= osc_ctrl_reg;
      osc_config_out  <= osc_cfg_reg;
      pin_config_out  <= pin_cfg_reg;
      alarm_event_out <= alarm_flag_reg;
      osc_fail_out    <= osc_fail_reg;
    end
  end

endmodule : rtcam_core

// *** rtcam_core_monitor.sv ***
// Purpose: bus, alarm and clock monitor checks on the core ports
// Assumes: zero-wait bus, main control at index 4, osc ctrl at 5
// Notes:   helper logic mirrors main control writes
`timescale 1ns/1ns
module rtcam_checker #(
  parameter int unsigned BLANK_CYCLES = 20
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // oscillator and events
  input wire logic        osc_clk_in,
  input wire logic        xtal_amp_ok_in,
  input wire logic        osc_power_out,
  input wire logic        alarm_event_out,
  input wire logic        osc_fail_out
);
  localparam int unsigned MISS = rtcam_pkg::MISS_CYCLES;
  logic        wr_reg;
  logic        rd_reg;
  logic        osc_reg;
  logic [3:0]  idx_reg;
  logic [7:0]  mc_reg;
  logic [2:0]  amp_reg;
  logic [1:0]  ae_reg;
  int unsigned idle_reg;
  int unsigned pw_reg;
  wire         take = hsel && hready && htrans == rtcam_pkg::HTRANS_NONSEQ;
  wire         rd5  = take && !hwrite && haddr[5:2] == 4'h5;
  wire         wr4  = wr_reg && idx_reg == 4'h4;

  // mirror of bus writes and pin histories
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      osc_reg  <= 1'b0;
      idx_reg  <= 4'h0;
      mc_reg   <= 8'h00;
      amp_reg  <= 3'h0;
      ae_reg   <= 2'h0;
      idle_reg <= 0;
      pw_reg   <= 0;
    end
    else
    begin
      wr_reg   <= take && hwrite && hsize == rtcam_pkg::HSIZE_WORD
                  && haddr[31:6] == 26'h0 && haddr[1:0] == 2'b00;
      rd_reg   <= take && !hwrite;
      idx_reg  <= haddr[5:2];
      osc_reg  <= osc_clk_in;
      if (wr4)
        mc_reg <= hwdata[7:0];
      amp_reg  <= xtal_amp_ok_in ? 3'h0 : (amp_reg == 3'h7 ? amp_reg : amp_reg + 3'h1);
      ae_reg   <= !alarm_event_out ? 2'h0 :
                  ((osc_clk_in && !osc_reg && ae_reg != 2'h3) ? ae_reg + 2'h1 : ae_reg);
      idle_reg <= (osc_clk_in != osc_reg || !mc_reg[6]) ? 0 :
                  (idle_reg > MISS + 20 ? idle_reg : idle_reg + 1);
      pw_reg   <= !osc_power_out ? 0 : (pw_reg > BLANK_CYCLES ? pw_reg : pw_reg + 1);
    end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  chk_rdata_idle: assert property (!rd_reg |-> hrdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_monitor_gate: assert property ($rose(osc_fail_out) |-> $past(mc_reg[6], 2))
    else $error("fail flag set with monitor off");
  chk_fail_set: assert property (idle_reg == MISS + 8 |-> osc_fail_out)
    else $error("fail flag missing after stalled oscillator");
  chk_xtal_low: assert property (rd5 && amp_reg >= 3'h4 |=> !hrdata[4])
    else $error("crystal valid read high with detector low");
  chk_xtal_blank: assert property (rd5 && pw_reg + 2 < BLANK_CYCLES |=> !hrdata[4])
    else $error("crystal valid read high during blanking");
  chk_alarm_gate: assert property ($rose(alarm_event_out) |-> $past(mc_reg[3], 2))
    else $error("alarm raised with alarm events off");
  chk_alarm_clear: assert property (wr4 && !hwdata[3] |-> ##2 !alarm_event_out)
    else $error("alarm not cleared by disabling events");
  chk_alarm_width: assert property (alarm_event_out |-> ae_reg < 2'h2)
    else $error("alarm held over a full oscillator cycle");
endmodule : rtcam_checker

bind rtcam_core rtcam_checker #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_clk_in(osc_clk_in),
  .xtal_amp_ok_in(xtal_amp_ok_in), .osc_power_out(osc_power_out),
  .alarm_event_out(alarm_event_out), .osc_fail_out(osc_fail_out));

// *** rtc_timer_alarm_clock_monitor_tb.sv ***
// Purpose: self-checking bench for the real-time clock core
// Assumes: zero-wait bus, short blanking parameter
// Notes:   oscillator pulses last 4 clk high, 4 clk low
`timescale 1ns/1ns
module rtc_timer_alarm_clock_monitor_tb;
  localparam int BLANK = 20;
  logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        osc_clk_in, xtal_amp_ok_in, osc_power_out, alarm_event_out, osc_fail_out;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  mc, q;
  logic [7:0]  oc_out, cf_out, pn_out;
  int          n_errors, tests_run;
  assign hready = hreadyout;

  rtcam_core #(.BLANK_CYCLES(BLANK)) uut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_clk_in(osc_clk_in),
    .xtal_amp_ok_in(xtal_amp_ok_in), .osc_power_out(osc_power_out),
    .osc_control_out(oc_out), .osc_config_out(cf_out), .pin_config_out(pn_out),
    .alarm_event_out(alarm_event_out), .osc_fail_out(osc_fail_out));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] i, input logic [7:0] d);
    @(posedge clk_sys);
    htrans <= rtcam_pkg::HTRANS_NONSEQ;
    haddr  <= {26'h0, i, 2'b00};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata[7:0];
  endtask : bus

  task automatic setmc(input logic [7:0] v);
    mc = v;
    bus(1'b1, 4'h4, v);
  endtask : setmc

  task automatic strobe(input int b);
    bus(1'b1, 4'h4, mc | (8'h01 << b));
    for (int k = 0; k < 20; k++)
    begin
      bus(1'b0, 4'h4, 8'h00);
      if (q[b] === 1'b0)
        break;
    end
    chk("strobe", 32'h0, {31'h0, q[b]});
  endtask : strobe

  task automatic ld(input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      bus(1'b1, i[3:0], v[8*i +: 8]);
    strobe(1);
  endtask : ld

  task automatic cap(input logic [31:0] e);
    logic [31:0] v;
    strobe(0);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, i[3:0], 8'h00);
      v[8*i +: 8] = q;
    end
    chk("counter", e, v);
  endtask : cap

  task automatic tick(input int n);
    repeat (n)
    begin
      osc_clk_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      osc_clk_in <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask : tick

  task automatic t_regs;
    bus(1'b0, 4'h4, 8'h00);
    chk("main ctrl", 32'h0, {24'h0, q});
    bus(1'b1, 4'hc, 8'hff);
    bus(1'b0, 4'hc, 8'h00);
    chk("unmapped", 32'h0, {24'h0, q});
  endtask : t_regs

  task automatic t_cfg;
    bus(1'b1, 4'h6, 8'h5a);
    bus(1'b1, 4'h7, 8'ha5);
    bus(1'b1, 4'h5, 8'h14);
    bus(1'b0, 4'h6, 8'h00);
    chk("osc cfg", 32'h5a, {24'h0, q});
    bus(1'b0, 4'h7, 8'h00);
    chk("pin cfg", 32'ha5, {24'h0, q});
    chk("cfg out", 32'h0014_5aa5, {8'h0, oc_out, cf_out, pn_out});
    bus(1'b1, 4'h5, 8'h00);
  endtask : t_cfg

  task automatic t_count;
    setmc(8'h80);
    ld(32'h1234_5678);
    cap(32'h1234_5678);
    setmc(8'h90);
    ld(32'h0000_0100);
    tick(5);
    cap(32'h0000_0105);
    bus(1'b1, 4'h5, 8'h08);
    tick(3);
    cap(32'h0000_010b);
    bus(1'b1, 4'h5, 8'h00);
    ld(32'hffff_fffe);
    tick(3);
    cap(32'h0000_0001);
    setmc(8'h80);
    tick(2);
    cap(32'h0000_0001);
  endtask : t_count

  task automatic t_alarm;
    for (int i = 0; i < 4; i++)
      bus(1'b1, 4'h8 + i[3:0], (i == 0) ? 8'h05 : 8'h00);
    setmc(8'h98);
    ld(32'h0);
    tick(5);
    chk("alarm", 32'h1, {31'h0, alarm_event_out});
    bus(1'b0, 4'h4, 8'h00);
    chk("alarm flag", 32'h1, {31'h0, q[2]});
    tick(1);
    chk("alarm", 32'h0, {31'h0, alarm_event_out});
    ld(32'h0);
    tick(5);
    setmc(8'h90);
    repeat (2) @(posedge clk_sys);
    chk("alarm", 32'h0, {31'h0, alarm_event_out});
    setmc(8'h98);
    tick(1);
    chk("alarm", 32'h0, {31'h0, alarm_event_out});
    setmc(8'h9c);
    ld(32'h0);
    tick(8);
    setmc(8'h80);
    cap(32'h0000_0001);
  endtask : t_alarm

  task automatic t_miss;
    repeat (2100) @(posedge clk_sys);
    chk("fail", 32'h0, {31'h0, osc_fail_out});
    setmc(8'hc0);
    repeat (2100) @(posedge clk_sys);
    chk("fail", 32'h1, {31'h0, osc_fail_out});
    bus(1'b0, 4'h4, 8'h00);
    chk("fail flag", 32'h1, {31'h0, q[5]});
    setmc(8'h80);
  endtask : t_miss

  task automatic t_xtal;
    bus(1'b1, 4'h5, 8'h10);
    bus(1'b0, 4'h5, 8'h00);
    chk("osc ctrl", 32'h0, {24'h0, q});
    xtal_amp_ok_in <= 1'b1;
    setmc(8'h00);
    setmc(8'h80);
    bus(1'b0, 4'h5, 8'h00);
    chk("xtal valid", 32'h0, {31'h0, q[4]});
    repeat (2 * BLANK) @(posedge clk_sys);
    bus(1'b0, 4'h5, 8'h00);
    chk("xtal valid", 32'h1, {31'h0, q[4]});
  endtask : t_xtal

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    rst            = 1'b1;
    hsel           = 1'b1;
    haddr          = 32'h0;
    htrans         = 2'b00;
    hwrite         = 1'b0;
    hsize          = rtcam_pkg::HSIZE_WORD;
    hwdata         = 32'h0;
    osc_clk_in     = 1'b0;
    xtal_amp_ok_in = 1'b0;
    mc             = 8'h00;
    n_errors       = 0;
    tests_run      = 0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_cfg;
    t_count;
    t_alarm;
    t_miss;
    t_xtal;
    end_sim;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    end_sim;
  end
endmodule : rtc_timer_alarm_clock_monitor_tb
